// >>> design/stx_top.sv
// stx_top: serial transmit framing, shifter and sample-rate generator with AXI4-Lite regs
// assumes all pins synchronous to i_clk; external serial device samples o_tx_data on strobe
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module stx_top
   import stx_pkg::*;
(
   input  wire logic        i_clk,              // 20 MHz core clock
   input  wire logic        i_rst_n,            // async reset, active low
   input  wire logic        i_s_axi_awvalid,    // write address valid
   output logic             o_s_axi_awready,    // write address ready
   input  wire logic [3:0]  i_s_axi_awaddr,     // write byte address
   input  wire logic        i_s_axi_wvalid,     // write data valid
   output logic             o_s_axi_wready,     // write data ready
   input  wire logic [31:0] i_s_axi_wdata,      // write data
   input  wire logic [3:0]  i_s_axi_wstrb,      // byte enables
   output logic             o_s_axi_bvalid,     // write response valid
   input  wire logic        i_s_axi_bready,     // write response ready
   output logic [1:0]       o_s_axi_bresp,      // write response
   input  wire logic        i_s_axi_arvalid,    // read address valid
   output logic             o_s_axi_arready,    // read address ready
   input  wire logic [3:0]  i_s_axi_araddr,     // read byte address
   output logic             o_s_axi_rvalid,     // read data valid
   input  wire logic        i_s_axi_rready,     // read data ready
   output logic [31:0]      o_s_axi_rdata,      // read data
   output logic [1:0]       o_s_axi_rresp,      // read response
   input  wire logic        i_external_source_clock, // external generator clock pin
   input  wire logic        i_rx_frame_sync,    // receive frame sync pin
   output logic             o_divided_bit_clock, // one-cycle strobe per divided period
   output logic             o_tx_frame_sync,    // transmit frame sync
   output logic             o_tx_data           // serial data out
);
   import stx_pkg::*;

   logic [31:0] tx_ctrl_reg, srg_cfg_reg, hold_reg;
   logic        hold_full_reg, busy_reg, fsg_reg, fsg_pend_reg;
   logic        aw_held_reg, w_held_reg, ext_d_reg, rxfs_d_reg;
   logic [3:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic [7:0]  div_cnt_reg;
   logic [11:0] per_cnt_reg;
   logic [7:0]  wid_cnt_reg;
   logic [6:0]  word_idx_reg;
   logic [5:0]  bits_left_reg;
   logic [31:0] shift_reg;

   // bit-reverse helper for the lsb-first path
   function automatic logic [31:0] stx_rev(input logic [31:0] d);
      logic [31:0] r;
      r = '0;
      for (int k = 0; k < 32; k++)
         r[k] = d[31-k];
      return r;
   endfunction

   // field decode
   wire  [6:0] frame_len   = tx_ctrl_reg[STX_FRLEN_LSB +: 7];
   wire  [2:0] wl_code     = tx_ctrl_reg[STX_WDLEN_LSB +: 3];
   wire        rev_en      = tx_ctrl_reg[STX_REV_BIT];
   wire        resync_en   = srg_cfg_reg[STX_RESYNC_BIT];
   wire        ext_pol     = srg_cfg_reg[STX_POL_BIT];
   wire        clk_sel     = srg_cfg_reg[STX_CLKSEL_BIT];
   wire        tx_frame_sync_source        = srg_cfg_reg[STX_TX_FRAME_SYNC_SOURCE_BIT];
   wire [11:0] frame_period        = srg_cfg_reg[STX_FRAME_PERIOD_LSB +: 12];
   wire  [7:0] frame_pulse_width        = srg_cfg_reg[STX_FRAME_PULSE_WIDTH_LSB +: 8];
   wire  [7:0] divider     = srg_cfg_reg[7:0];

   // word length decode; reserved codes fall back to 8 bits
   logic [5:0] wlen_bits;
   always_comb
   begin
      case (wl_code)
         STX_WL_8:  wlen_bits = 6'h08;
         STX_WL_12: wlen_bits = 6'h0C;
         STX_WL_16: wlen_bits = 6'h10;
         STX_WL_20: wlen_bits = 6'h14;
         STX_WL_24: wlen_bits = 6'h18;
         STX_WL_32: wlen_bits = 6'h20;
         default:   wlen_bits = 6'h08;
      endcase
   end

   // generator input: pin edges compare the pin with its prior sample, so an edge is seen in the cycle it arrives
   wire ext_edge  = ext_pol ? (ext_d_reg & ~i_external_source_clock)
                            : (~ext_d_reg & i_external_source_clock);
   wire src_tick  = clk_sel ? 1'b1 : ext_edge;
   wire resync    = resync_en & ~clk_sel;
   wire rx_rise   = i_rx_frame_sync & ~rxfs_d_reg;
   wire divided_bit_clock_tick = src_tick & (div_cnt_reg == divider) & ~(resync & rx_rise);
   wire per_start = divided_bit_clock_tick & (per_cnt_reg == 12'h000) & ~resync;
   wire fsg_start = resync ? rx_rise : per_start;
   wire fr_ok     = ~tx_frame_sync_source | (word_idx_reg != 7'h00) | fsg_pend_reg;
   wire load      = divided_bit_clock_tick & hold_full_reg & ~busy_reg & fr_ok;
   wire [31:0] load_word = rev_en ? stx_rev(hold_reg)
                                  : (hold_reg << (6'h20 - wlen_bits));

   // sampled pin copies and clock divider
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ext_d_reg   <= 1'b0;
         rxfs_d_reg  <= 1'b0;
         div_cnt_reg <= 8'h00;
      end
      else
      begin
         ext_d_reg  <= i_external_source_clock;
         rxfs_d_reg <= i_rx_frame_sync;
         if (resync & rx_rise)
            div_cnt_reg <= 8'h00;
         else if (src_tick)
            div_cnt_reg <= (div_cnt_reg == divider) ? 8'h00 : div_cnt_reg + 8'h01;
      end
   end

   // frame period and pulse width; period stalls while resync owns the timing
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         per_cnt_reg  <= 12'h000;
         wid_cnt_reg  <= 8'h00;
         fsg_reg      <= 1'b0;
         fsg_pend_reg <= 1'b0;
      end
      else
      begin
         if (resync & rx_rise)
            per_cnt_reg <= frame_period;
         else if (per_start)
            per_cnt_reg <= frame_period;
         else if (divided_bit_clock_tick & ~resync)
            per_cnt_reg <= per_cnt_reg - 12'h001;
         if (fsg_start)
         begin
            fsg_reg     <= 1'b1;
            wid_cnt_reg <= frame_pulse_width;
         end
         else if (divided_bit_clock_tick & fsg_reg)
         begin
            fsg_reg     <= (wid_cnt_reg != 8'h00);
            wid_cnt_reg <= wid_cnt_reg - 8'h01;
         end
         // a sync arriving with the load is kept, set wins
         fsg_pend_reg <= fsg_start | (fsg_pend_reg & ~load);
      end
   end

   // shifter and frame word counter
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         shift_reg     <= 32'h00000000;
         bits_left_reg <= 6'h00;
         busy_reg      <= 1'b0;
         word_idx_reg  <= 7'h00;
      end
      else if (load)
      begin
         shift_reg     <= load_word;
         bits_left_reg <= wlen_bits;
         busy_reg      <= 1'b1;
         // >= so a frame length shortened mid-frame still wraps at once
         word_idx_reg  <= (word_idx_reg >= frame_len) ? 7'h00 : word_idx_reg + 7'h01;
      end
      else if (divided_bit_clock_tick & busy_reg)
      begin
         shift_reg     <= {shift_reg[30:0], 1'b0};
         bits_left_reg <= bits_left_reg - 6'h01;
         busy_reg      <= (bits_left_reg != 6'h01);
      end
   end

   // serial pin drivers, all registered
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_tx_data           <= 1'b0;
         o_tx_frame_sync     <= 1'b0;
         o_divided_bit_clock <= 1'b0;
      end
      else
      begin
         o_divided_bit_clock <= divided_bit_clock_tick;
         if (divided_bit_clock_tick & busy_reg)
            o_tx_data <= shift_reg[31];
         o_tx_frame_sync <= tx_frame_sync_source ? fsg_reg : load;
      end
   end

   // write channel decode
   wire aw_take  = i_s_axi_awvalid & o_s_axi_awready;
   wire w_take   = i_s_axi_wvalid & o_s_axi_wready;
   wire wr_go    = aw_held_reg & w_held_reg & ~o_s_axi_bvalid;
   wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                        {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire wr_ctl   = wr_go & (awaddr_reg == STX_TX_CTRL_OFS);
   wire wr_srg   = wr_go & (awaddr_reg == STX_SRG_CFG_OFS);
   wire wr_hold  = wr_go & (awaddr_reg == STX_TX_HOLD_OFS);
   wire wr_ok    = wr_ctl | wr_srg | wr_hold | (awaddr_reg == STX_STATUS_OFS);

   // write path; a holding write while full is dropped so unsent data survives
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         aw_held_reg     <= 1'b0;
         w_held_reg      <= 1'b0;
         awaddr_reg      <= 4'h0;
         wdata_reg       <= 32'h00000000;
         wstrb_reg       <= 4'h0;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= STX_RESP_OKAY;
         tx_ctrl_reg     <= STX_TX_CTRL_RST;
         srg_cfg_reg     <= STX_SRG_RST;
         hold_reg        <= 32'h00000000;
         hold_full_reg   <= 1'b0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= {i_s_axi_awaddr[3:2], 2'b00};
         end
         if (w_take)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= i_s_axi_wdata;
            wstrb_reg  <= i_s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= wr_ok ? STX_RESP_OKAY : STX_RESP_SLVERR;
         end
         else if (i_s_axi_bready)
            o_s_axi_bvalid <= 1'b0;
         if (wr_ctl)
            tx_ctrl_reg <= ((tx_ctrl_reg & ~wmask) | (wdata_reg & wmask))
                           & STX_TX_CTRL_MASK;
         if (wr_srg)
            srg_cfg_reg <= (srg_cfg_reg & ~wmask) | (wdata_reg & wmask);
         if (wr_hold & ~hold_full_reg)
            hold_reg <= (hold_reg & ~wmask) | (wdata_reg & wmask);
         hold_full_reg <= (wr_hold & ~hold_full_reg) | (hold_full_reg & ~load);
      end
   end

   always_comb o_s_axi_awready = ~aw_held_reg;
   always_comb o_s_axi_wready  = ~w_held_reg;

   // read path
   wire [3:0]  raddr = {i_s_axi_araddr[3:2], 2'b00};
   wire [31:0] status = {16'h0000, frame_len == 7'h00, word_idx_reg,
                         6'h00, busy_reg, ~hold_full_reg};
   wire        rd_ok = (raddr != STX_TX_HOLD_OFS);
   wire [31:0] rd_mux = (raddr == STX_TX_CTRL_OFS) ? tx_ctrl_reg :
                        (raddr == STX_SRG_CFG_OFS) ? srg_cfg_reg :
                        (raddr == STX_STATUS_OFS)  ? status : 32'h00000000;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata  <= 32'h00000000;
         o_s_axi_rresp  <= STX_RESP_OKAY;
      end
      else if (i_s_axi_arvalid & o_s_axi_arready)
      begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata  <= rd_mux;
         o_s_axi_rresp  <= rd_ok ? STX_RESP_OKAY : STX_RESP_SLVERR;
      end
      else if (i_s_axi_rready)
         o_s_axi_rvalid <= 1'b0;
   end

   always_comb o_s_axi_arready = ~o_s_axi_rvalid;

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_frame_wrap: assert property (load && word_idx_reg >= frame_len
      |=> word_idx_reg == 7'h00) else $error("frame word count did not wrap");
   a_word_bits: assert property (load |=> bits_left_reg == $past(wlen_bits)
      && busy_reg) else $error("word bit count wrong");
   a_rev_load: assert property (load && rev_en |=> shift_reg == stx_rev($past(hold_reg)))
      else $error("reversed word not loaded lsb first");
   a_ctrl_low_zero: assert property (tx_ctrl_reg[3:0] == 4'h0)
      else $error("tx control low bits not zero");
   a_msb_out: assert property (divided_bit_clock_tick && busy_reg |=> o_tx_data == $past(shift_reg[31]))
      else $error("serial bit not taken from shifter top");
   a_clk_select: assert property (clk_sel ? src_tick
      : (src_tick == (i_external_source_clock != $past(i_external_source_clock)
                      && i_external_source_clock != ext_pol)))
      else $error("generator source select wrong");
   a_period_load: assert property (per_start |=> per_cnt_reg == $past(frame_period) && fsg_reg)
      else $error("frame period not reloaded");
   a_copy_sync: assert property (load && !tx_frame_sync_source |=> o_tx_frame_sync)
      else $error("no frame sync on copy");
   a_resync_align: assert property (resync && rx_rise |=> div_cnt_reg == 8'h00 && fsg_reg)
      else $error("resync did not realign");

   c_copy: cover property (load ##[1:200] load);
   c_rev: cover property (load && rev_en);
   c_resync: cover property (resync && rx_rise);
   c_period: cover property (per_start && tx_frame_sync_source);
endmodule

// >>> design/stx_pkg.sv
// stx_pkg: constants for the serial transmit framing and sample-rate generator block
// assumes a 32-bit AXI4-Lite register bus and one 20 MHz core clock
package stx_pkg;
   // register byte addresses
   localparam logic [3:0]  STX_TX_CTRL_OFS   = 4'h0;
   localparam logic [3:0]  STX_SRG_CFG_OFS   = 4'h4;
   localparam logic [3:0]  STX_TX_HOLD_OFS   = 4'h8;
   localparam logic [3:0]  STX_STATUS_OFS    = 4'hC;
   // tx control fields
   localparam int          STX_FRLEN_LSB     = 8;
   localparam int          STX_WDLEN_LSB     = 5;
   localparam int          STX_REV_BIT       = 4;
   localparam logic [31:0] STX_TX_CTRL_MASK  = 32'h00007FF0;
   localparam logic [31:0] STX_TX_CTRL_RST   = 32'h00000000;
   // sample-rate generator fields
   localparam int          STX_RESYNC_BIT    = 31;
   localparam int          STX_POL_BIT       = 30;
   localparam int          STX_CLKSEL_BIT    = 29;
   localparam int          STX_TX_FRAME_SYNC_SOURCE_BIT      = 28;
   localparam int          STX_FRAME_PERIOD_LSB      = 16;
   localparam int          STX_FRAME_PULSE_WIDTH_LSB      = 8;
   localparam logic [31:0] STX_SRG_RST       = 32'h20000001;
   // word length codes
   localparam logic [2:0]  STX_WL_8          = 3'h0;
   localparam logic [2:0]  STX_WL_12         = 3'h1;
   localparam logic [2:0]  STX_WL_16         = 3'h2;
   localparam logic [2:0]  STX_WL_20         = 3'h3;
   localparam logic [2:0]  STX_WL_24         = 3'h4;
   localparam logic [2:0]  STX_WL_32         = 3'h5;
   // axi responses
   localparam logic [1:0]  STX_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  STX_RESP_SLVERR   = 2'h2;
endpackage

// >>> bench/stx_link_partner.sv
// stx_link_partner: far-side serial device of the transmit link
// assumes divided strobes at least 8 core cycles apart while data is checked
`timescale 1ns/1ns
module stx_link_partner
(
   input  wire logic       i_clk,      // core clock
   input  wire logic       i_rst_n,    // async reset, active low
   input  wire logic       i_strobe,   // divided clock strobe
   input  wire logic       i_data,     // serial data
   input  wire logic       i_fsync,    // tx frame sync
   input  wire logic       i_ext_run,  // source clock runs
   input  wire logic [3:0] i_ext_half, // source half period in cycles
   input  wire logic       i_rx_req,   // bench asks for rx sync
   output logic            o_ext_clk,  // external source clock
   output logic            o_rx_fsync, // rx frame sync
   output logic [31:0]     o_hist,     // bits seen, newest at bit 0
   output logic [7:0]      o_cnt       // samples since last sync
);
   logic [3:0] half_reg;
   logic [1:0] dly_reg;
   logic       fs_reg;
   // source clock stands low while stopped, so no stray ticks
   always_ff @(posedge i_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         half_reg  <= 4'h0;
         o_ext_clk <= 1'b0;
      end
      else if (!i_ext_run || half_reg == i_ext_half - 4'h1)
      begin
         half_reg  <= 4'h0;
         o_ext_clk <= i_ext_run & ~o_ext_clk;
      end
      else
         half_reg <= half_reg + 4'h1;
   // sample mid-way between strobes, clear of either update edge
   always_ff @(posedge i_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         dly_reg    <= 2'h0;
         fs_reg     <= 1'b0;
         o_hist     <= 32'h0;
         o_cnt      <= 8'h0;
         o_rx_fsync <= 1'b0;
      end
      else
      begin
         o_rx_fsync <= i_rx_req;
         fs_reg     <= i_fsync;
         dly_reg    <= i_strobe ? 2'h3 : dly_reg - {1'b0, dly_reg != 2'h0};
         if (dly_reg == 2'h1)
            o_hist <= {o_hist[30:0], i_data};
         if (i_fsync && !fs_reg)
            o_cnt <= 8'h0;
         else if (dly_reg == 2'h1 && o_cnt != 8'hFF)
            o_cnt <= o_cnt + 8'h1; // saturates so a stale count never matches
      end
endmodule

// >>> bench/serial_tx_format_and_srg_config_tb.sv
// serial_tx_format_and_srg_config_tb: self-checking bench for stx_top
// assumes stx_link_partner on the serial side and a 20 MHz core clock
`timescale 1ns/1ns
module serial_tx_format_and_srg_config_tb;
   import stx_pkg::*;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ext_run, rx_req;
   logic [3:0]  awaddr, araddr, wstrb, ext_half;
   logic [31:0] wdata, rv, w, e;
   wire         awready, wready, bvalid, arready, rvalid, tick, tx_frame_sync, txd, ext_clk, rx_fs;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata, hist;
   wire  [7:0]  cnt;
   int          error_cnt, checked, i, p, q, hi, lo, wl_tab [8];
   // core clock
   always #25 clk = ~clk;
   stx_top stx_top_i (
      .i_clk(clk), .i_rst_n(rst_n), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .i_external_source_clock(ext_clk), .i_rx_frame_sync(rx_fs),
      .o_divided_bit_clock(tick), .o_tx_frame_sync(tx_frame_sync), .o_tx_data(txd));
   stx_link_partner stx_link_partner_i (
      .i_clk(clk), .i_rst_n(rst_n), .i_strobe(tick), .i_data(txd), .i_fsync(tx_frame_sync),
      .i_ext_run(ext_run), .i_ext_half(ext_half), .i_rx_req(rx_req), .o_ext_clk(ext_clk),
      .o_rx_fsync(rx_fs), .o_hist(hist), .o_cnt(cnt));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t %s: seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   // requests move just after a rising edge; readies and answers are taken at that edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      logic       tb;
      logic [1:0] r;
      int         n;
      n = 0;
      tb = 1'b0;
      r = 2'h3;
      @(posedge clk);
      {awvalid, wvalid, bready} <= 3'h7;
      {awaddr, wdata, wstrb} <= {a, d, s};
      while (!tb && n < 200)
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            tb = 1'b1;
            r = bresp;
         end
         n++;
      end
      bready <= 1'b0;
      chk({tb, 29'h0, r}, {1'b1, 29'h0, STX_RESP_OKAY}, "write answer");
   endtask
   task automatic rd(input logic [3:0] a, input logic [1:0] er, input logic [31:0] ed,
                     input logic [31:0] m);
      logic       tr;
      logic [1:0] r;
      int         n;
      n = 0;
      tr = 1'b0;
      r = 2'h3;
      @(posedge clk);
      {arvalid, rready, araddr} <= {2'h3, a};
      while (!tr && n < 200)
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            tr = 1'b1;
            rv = rdata;
            r = rresp;
         end
         n++;
      end
      rready <= 1'b0;
      chk({tr, 29'h0, r}, {1'b1, 29'h0, er}, "read answer");
      chk(rv & m, ed & m, "read data");
   endtask
   task automatic wlev(input logic v, output int c);
      c = 0;
      // long limit: a stale period count may run up to 4096 ticks first
      while (tx_frame_sync !== v && c < 10000)
      begin
         @(negedge clk);
         c++;
      end
   endtask
   task automatic rises(input int cyc, output int k);
      logic prev;
      k = 0;
      prev = tx_frame_sync;
      repeat (cyc)
      begin
         @(negedge clk);
         if (tx_frame_sync === 1'b1 && prev !== 1'b1) k++;
         prev = tx_frame_sync;
      end
   endtask
   // copy sync may come before the write answer, so watch it alongside
   task automatic send(input int nb, input logic [31:0] exp);
      int c;
      fork
         wr(STX_TX_HOLD_OFS, w, 4'hF);
         begin
            wlev(1'b1, c);
            @(negedge clk);
            chk({31'h0, tx_frame_sync}, 32'h0, "copy sync width");
         end
      join
      c = 0;
      while (cnt !== 8'(nb + 1) && c < 1200)
      begin
         @(negedge clk);
         c++;
      end
      e = (nb > 31) ? 32'hFFFFFFFF : (32'h1 << nb) - 32'h1;
      chk(hist & e, exp & e, "word bits");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog: the tests need well under 20000 cycles
   initial
   begin
      repeat (40000) @(posedge clk);
      chk(32'h0, 32'h1, "watchdog expired");
      wrap_up();
   end
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, ext_run, rx_req} = '0;
      {awaddr, araddr, wstrb, wdata} = '0;
      ext_half = 4'h3;
      error_cnt = 0;
      checked = 0;
      wl_tab = '{8, 12, 16, 20, 24, 32, 8, 8};
      void'($urandom(32'hC1EE));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(STX_TX_CTRL_OFS, STX_RESP_OKAY, STX_TX_CTRL_RST, 32'hFFFFFFFF);
      rd(STX_SRG_CFG_OFS, STX_RESP_OKAY, STX_SRG_RST, 32'hFFFFFFFF);
      rd(STX_TX_HOLD_OFS, STX_RESP_SLVERR, 32'h0, 32'hFFFFFFFF);
      // reversal left off here: a reserved word length with it set is not allowed
      wr(STX_TX_CTRL_OFS, 32'hFFFFFFEF, 4'hF);
      rd(STX_TX_CTRL_OFS, STX_RESP_OKAY, 32'h00007FE0, 32'hFFFFFFFF);
      wr(STX_SRG_CFG_OFS, 32'hFFFFFFFF, 4'h1);
      rd(STX_SRG_CFG_OFS, STX_RESP_OKAY, 32'h200000FF, 32'hFFFFFFFF);
      $display("test registers done");
      // mode 0 with random period and width, which the copy sync ignores
      wr(STX_SRG_CFG_OFS, {4'h2, 12'($urandom), 8'($urandom), 8'h07}, 4'hF);
      for (i = 0; i < 8; i++)
      begin
         wr(STX_TX_CTRL_OFS, {17'h0, 7'h7F, 3'(i), 1'b0, 4'h0}, 4'hF);
         w = $urandom;
         send(wl_tab[i], w);
      end
      // reversal is only legal with 32-bit words
      wr(STX_TX_CTRL_OFS, {17'h0, 7'h7F, STX_WL_32, 1'b1, 4'h0}, 4'hF);
      for (i = 0; i < 3; i++)
      begin
         w = (i == 0) ? 32'h00000001 : $urandom;
         e = {<<{w}};
         send(32, e);
      end
      $display("test word format done");
      wr(STX_TX_CTRL_OFS, {17'h0, 7'h02, STX_WL_8, 1'b0, 4'h0}, 4'hF);
      for (i = 0; i < 4; i++)
      begin
         w = $urandom;
         send(8, {24'h0, w[7:0]});
         // the stale index from the long frames wraps on the first copy
         rd(STX_STATUS_OFS, STX_RESP_OKAY, {16'h0, 1'b0, 7'(i % 3), 8'h01}, 32'h0000FF03);
         chk({25'h0, rv[14:8]}, 32'(i % 3), "word index");
      end
      $display("test frame length done");
      for (i = 0; i < 3; i++)
      begin
         p = 2 + $urandom % 8;
         q = $urandom % p;
         wr(STX_SRG_CFG_OFS, {4'h3, 12'(p), 8'(q), 8'h01}, 4'hF);
         wlev(1'b0, hi);
         wlev(1'b1, hi);
         wlev(1'b0, hi);
         wlev(1'b1, lo);
         chk(32'(hi + lo), 32'((p + 1) * 2), "sync spacing");
         chk(32'(hi), 32'((q + 1) * 2), "sync width");
      end
      $display("test generated sync done");
      wr(STX_SRG_CFG_OFS, {4'h1, 12'h001, 8'h00, 8'h00}, 4'hF);
      rises(200, p);
      chk(32'(p), 32'h0, "no pin clock");
      ext_run <= 1'b1;
      wlev(1'b0, hi);
      wlev(1'b1, hi);
      wlev(1'b0, hi);
      wlev(1'b1, lo);
      chk(32'(hi + lo), 32'h0000000C, "pin clock spacing");
      $display("test clock source done");
      ext_half <= 4'h2;
      wr(STX_SRG_CFG_OFS, {4'h9, 12'h000, 8'h00, 8'h01}, 4'hF);
      rises(60, p);
      for (i = 0; i < 3; i++)
      begin
         fork
            begin
               @(posedge clk);
               rx_req <= 1'b1;
               repeat (4) @(posedge clk);
               rx_req <= 1'b0;
            end
            rises(40, p);
         join
         rises(60, q);
         chk({16'(p), 16'(q)}, 32'h00010000, "resync sync count");
      end
      $display("test resync done");
      wrap_up();
   end
endmodule
